// *** plc_pkg.sv ***
`default_nettype none
package plc_pkg;
   localparam logic [4:0]  PLC_ADDR_LINK_CTRL  = 5'h17;
   localparam logic [4:0]  PLC_ADDR_INT_MASK   = 5'h18;
   localparam logic [4:0]  PLC_ADDR_INT_STATUS = 5'h19;
   localparam logic [15:0] PLC_LINK_CTRL_RST   = 16'h3048;
   localparam logic [15:0] PLC_INT_MASK_RST    = 16'h0000;
   localparam int          PLC_LINK_EN_BIT     = 13;
   localparam int          PLC_RETRY_LSB       = 10;
   localparam int          PLC_RETRY_W         = 3;
   localparam int          PLC_PIN_EN_BIT      = 0;
   localparam int          PLC_SRC_LSB         = 1;
   localparam int          PLC_SRC_N           = 10;
   localparam int          PLC_SRC_SPEED       = 0;
   localparam int          PLC_SRC_LINK        = 1;
   localparam int          PLC_SRC_RECEIVE     = 2;
   localparam int          PLC_SRC_FIFO        = 3;
   localparam int          PLC_SRC_IDLE        = 4;
   localparam int          PLC_SRC_PAGE        = 5;
   localparam int          PLC_SRC_FRAME       = 6;
   localparam int          PLC_SRC_AUTONEG     = 7;
   localparam int          PLC_SRC_SYNC        = 8;
   localparam int          PLC_SRC_CABLE       = 9;
   localparam logic [15:0] PLC_LINK_WMASK      = 16'h3FFF;
   localparam logic [15:0] PLC_INT_MASK_WMASK  = 16'hFFFF;
endpackage : plc_pkg
`default_nettype wire

// *** plc_link_ctrl_irq_mask.sv ***
`default_nettype none
module plc_link_ctrl_irq_mask
   import plc_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   nrst,
   input  wire logic [4:0]             reg_addr,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [15:0]            reg_wdata,
   output logic      [15:0]            reg_rdata,
   input  wire logic [PLC_SRC_N-1:0]   int_event,
   output logic                        link_attempt_enable,
   output logic                        standby,
   output logic      [PLC_RETRY_W-1:0] speed_retry_count,
   output logic                        int_n
);
   // Everything but the synchroniser runs on the released reset copy.
   logic                        rst_s1_reg;
   logic                        rst_s2_reg;
   logic [15:0]                 link_ctrl_reg;
   logic [15:0]                 link_ctrl_next;
   logic [15:0]                 int_mask_reg;
   logic [15:0]                 int_mask_next;
   logic [PLC_SRC_N-1:0]        status_reg;
   logic                        pending_reg;
   logic                        pending_next;
   logic [15:0]                 rdata_next;

   wire logic                   hit_link;
   wire logic                   hit_mask;
   wire logic                   hit_status;
   wire logic                   wr_link;
   wire logic                   wr_mask;
   wire logic                   rd_link;
   wire logic                   rd_mask;
   wire logic                   rd_status;
   wire logic                   rd_unmapped;
   wire logic                   keep_flags;

   wire logic                   link_en_field;
   wire logic [PLC_RETRY_W-1:0] retry_field;
   wire logic [1:0]             link_resv_high;
   wire logic [9:0]             link_resv_low;
   wire logic [4:0]             mask_resv;
   wire logic                   pin_enable;
   wire logic [PLC_SRC_N-1:0]   src_enable;
   wire logic [15:0]            link_word;
   wire logic [15:0]            mask_word;
   wire logic [15:0]            status_word;

   wire logic [PLC_SRC_N-1:0]   status_next;
   wire logic [PLC_SRC_N-1:0]   src_gated;
   wire logic                   gate_speed;
   wire logic                   gate_link;
   wire logic                   gate_receive;
   wire logic                   gate_fifo;
   wire logic                   gate_idle;
   wire logic                   gate_page;
   wire logic                   gate_frame;
   wire logic                   gate_autoneg;
   wire logic                   gate_sync;
   wire logic                   gate_cable;
   wire logic                   any_enabled;
   wire logic                   pin_assert;

   function automatic logic addr_match(
      input logic [4:0] addr,
      input logic [4:0] target
   );
      return addr == target;
   endfunction : addr_match

   function automatic logic [15:0] merge_write(
      input logic [15:0] old_value,
      input logic [15:0] new_value,
      input logic [15:0] write_mask
   );
      return (new_value & write_mask) | (old_value & ~write_mask);
   endfunction : merge_write

   function automatic logic gate_source(
      input logic [PLC_SRC_N-1:0] flags,
      input logic [PLC_SRC_N-1:0] enables,
      input int                   index
   );
      return flags[index] & enables[index];
   endfunction : gate_source

   assign hit_link    = addr_match(reg_addr, PLC_ADDR_LINK_CTRL);
   assign hit_mask    = addr_match(reg_addr, PLC_ADDR_INT_MASK);
   assign hit_status  = addr_match(reg_addr, PLC_ADDR_INT_STATUS);

   assign wr_link     = reg_wr & hit_link;
   assign wr_mask     = reg_wr & hit_mask;

   assign rd_link     = reg_rd & hit_link;
   assign rd_mask     = reg_rd & hit_mask;
   assign rd_status   = reg_rd & hit_status;
   assign rd_unmapped = reg_rd & ~(hit_link | hit_mask | hit_status);
   assign keep_flags  = ~rd_status;

   // Staged release so that no register past the synchroniser leaves reset a cycle before another.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   assign link_en_field  = link_ctrl_reg[PLC_LINK_EN_BIT];
   assign retry_field    = link_ctrl_reg[PLC_RETRY_LSB +: PLC_RETRY_W];
   assign link_resv_high = link_ctrl_reg[15:PLC_LINK_EN_BIT + 1];
   assign link_resv_low  = link_ctrl_reg[PLC_RETRY_LSB - 1:0];

   assign pin_enable     = int_mask_reg[PLC_PIN_EN_BIT];
   assign src_enable     = int_mask_reg[PLC_SRC_LSB +: PLC_SRC_N];
   assign mask_resv      = int_mask_reg[15:PLC_SRC_LSB + PLC_SRC_N];

   assign link_word = {
      link_resv_high,
      link_en_field,
      retry_field,
      link_resv_low
   };

   assign mask_word = {
      mask_resv,
      src_enable,
      pin_enable
   };

   // Reserved status bits are tied low; they hold no storage.
   assign status_word = {
      5'h00,
      status_reg,
      pending_reg
   };

   assign link_ctrl_next = wr_link
                         ? merge_write(link_ctrl_reg, reg_wdata, PLC_LINK_WMASK)
                         : link_ctrl_reg;

   assign int_mask_next  = wr_mask
                         ? merge_write(int_mask_reg, reg_wdata, PLC_INT_MASK_WMASK)
                         : int_mask_reg;

   always_ff @(posedge ref_clk or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
         link_ctrl_reg <= PLC_LINK_CTRL_RST;
      end else begin
         link_ctrl_reg <= link_ctrl_next;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
         int_mask_reg <= PLC_INT_MASK_RST;
      end else begin
         int_mask_reg <= int_mask_next;
      end
   end

   // Flags ignore mask.
   // A new event in the clearing cycle wins, so no event is lost.
   generate
      for (genvar i = 0; i < PLC_SRC_N; i++) begin : g_flag
         assign status_next[i] = int_event[i] | (status_reg[i] & keep_flags);
      end
   endgenerate

   assign gate_speed = gate_source(
      status_next,
      src_enable,
      PLC_SRC_SPEED
   );

   assign gate_link = gate_source(
      status_next,
      src_enable,
      PLC_SRC_LINK
   );

   assign gate_receive = gate_source(
      status_next,
      src_enable,
      PLC_SRC_RECEIVE
   );

   assign gate_fifo = gate_source(
      status_next,
      src_enable,
      PLC_SRC_FIFO
   );

   assign gate_idle = gate_source(
      status_next,
      src_enable,
      PLC_SRC_IDLE
   );

   assign gate_page = gate_source(
      status_next,
      src_enable,
      PLC_SRC_PAGE
   );

   assign gate_frame = gate_source(
      status_next,
      src_enable,
      PLC_SRC_FRAME
   );

   assign gate_autoneg = gate_source(
      status_next,
      src_enable,
      PLC_SRC_AUTONEG
   );

   assign gate_sync = gate_source(
      status_next,
      src_enable,
      PLC_SRC_SYNC
   );

   assign gate_cable = gate_source(
      status_next,
      src_enable,
      PLC_SRC_CABLE
   );

   assign src_gated = {
      gate_cable,
      gate_sync,
      gate_autoneg,
      gate_frame,
      gate_page,
      gate_idle,
      gate_fifo,
      gate_receive,
      gate_link,
      gate_speed
   };

   assign any_enabled  = |src_gated;
   // Pending stays latched like the flags until the status read.
   assign pending_next = (pending_reg & keep_flags) | any_enabled;

   always_ff @(posedge ref_clk or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
         status_reg <= '0;
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
         pending_reg <= 1'b0;
      end else begin
         pending_reg <= pending_next;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= rdata_next;
      end
   end

   // Without a read the last word stays on the bus.
   always_comb begin
      rdata_next = reg_rdata;
      if (rd_link) begin
         rdata_next = link_word;
      end else if (rd_mask) begin
         rdata_next = mask_word;
      end else if (rd_status) begin
         rdata_next = status_word;
      end else if (rd_unmapped) begin
         rdata_next = 16'h0000;
      end
   end

   assign link_attempt_enable = link_en_field;
   assign standby             = ~link_en_field;

   assign speed_retry_count   = retry_field;

   assign pin_assert          = pending_reg & pin_enable;
   assign int_n               = ~pin_assert;
endmodule : plc_link_ctrl_irq_mask
`default_nettype wire

// *** plc_host.sv ***
`default_nettype none
module plc_host (
   input  wire logic        ref_clk,
   output logic      [4:0]  reg_addr = 5'h00,
   output logic             reg_wr = 1'b0,
   output logic             reg_rd = 1'b0,
   output logic      [15:0] reg_wdata = 16'h0000
);
   timeunit 1ns / 1ps;
   task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, ~w, a, d};
      @(posedge ref_clk);
      {reg_wr, reg_rd} <= 2'h0;
      #1;
   endtask : acc
endmodule : plc_host
`default_nettype wire

// *** plc_link_ctrl_irq_mask_assertions.sv ***
`default_nettype none
module plc_chk (
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic        link_attempt_enable,
   input wire logic        standby,
   input wire logic        int_n,
   input wire logic [4:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic [9:0]  int_event,
   input wire logic [2:0]  speed_retry_count
);
   timeunit 1ns / 1ps;
   logic [10:0] mask_reg;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) mask_reg <= '0;
      else if (reg_wr && reg_addr == 5'h18) mask_reg <= reg_wdata[10:0];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence ev_rd; int_event != 10'h0 ##1 !reg_rd ##1 reg_rd && reg_addr == 5'h19 && !reg_wr; endsequence
   a_reset_vals: assert property ($rose(nrst) |-> speed_retry_count == 3'h4 && link_attempt_enable && int_n)
      else $error("bad reset value");
   a_link_standby: assert property (link_attempt_enable != standby) else $error("standby wrong");
   a_write_link: assert property (reg_wr && reg_addr == 5'h17 |=>
      {link_attempt_enable, speed_retry_count} == $past(reg_wdata[13:10])) else $error("link write lost");
   a_read_link: assert property (reg_rd && reg_addr == 5'h17 |=>
      reg_rdata[15:10] == {2'h0, link_attempt_enable, speed_retry_count}) else $error("link read wrong");
   a_pin_gate: assert property (!mask_reg[0] |-> int_n) else $error("pin not gated");
   a_pend_on: assert property (mask_reg[0] && (int_event & mask_reg[10:1]) != 10'h0 |=> !int_n)
      else $error("pin not raised");
   a_masked_quiet: assert property (int_n && !reg_wr && (int_event & mask_reg[10:1]) == 10'h0 |=> int_n)
      else $error("masked source raised pin");
   a_read_clear: assert property (reg_rd && reg_addr == 5'h19 && int_event == 10'h0 |=> int_n)
      else $error("read did not clear");
   a_flag_stick: assert property (ev_rd |=> (reg_rdata[10:1] & $past(int_event, 3)) == $past(int_event, 3))
      else $error("flag lost");
endmodule : plc_chk
bind plc_link_ctrl_irq_mask plc_chk plc_chk_inst (
   .ref_clk             (ref_clk),
   .nrst                (nrst),
   .reg_wr              (reg_wr),
   .reg_rd              (reg_rd),
   .link_attempt_enable (link_attempt_enable),
   .standby             (standby),
   .int_n               (int_n),
   .reg_addr            (reg_addr),
   .reg_wdata           (reg_wdata),
   .reg_rdata           (reg_rdata),
   .int_event           (int_event),
   .speed_retry_count   (speed_retry_count)
);
`default_nettype wire

// *** plc_link_ctrl_irq_mask_tb.sv ***
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; $display("wrong value %0t %h %h", $time, a, e); end end
module plc_link_ctrl_irq_mask_tb;
   timeunit 1ns / 1ps;
   logic ref_clk = 1'b0, nrst = 1'b0, reg_wr, reg_rd, link_attempt_enable, standby, int_n;
   logic [9:0] int_event = 10'h0;
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [2:0] speed_retry_count;
   int err_total = 0, cmp_count = 0;
   always #4 ref_clk = !ref_clk;
   plc_host plc_host_inst (
      .ref_clk   (ref_clk),
      .reg_addr  (reg_addr),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_wdata (reg_wdata)
   );
   plc_link_ctrl_irq_mask plc_link_ctrl_irq_mask_inst (
      .ref_clk             (ref_clk),
      .nrst                (nrst),
      .reg_addr            (reg_addr),
      .reg_wr              (reg_wr),
      .reg_rd              (reg_rd),
      .reg_wdata           (reg_wdata),
      .reg_rdata           (reg_rdata),
      .int_event           (int_event),
      .link_attempt_enable (link_attempt_enable),
      .standby             (standby),
      .speed_retry_count   (speed_retry_count),
      .int_n               (int_n)
   );
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      plc_host_inst.acc(1'b0, a, 16'h0000);
      `CHK(reg_rdata, e)
   endtask : rd
   task automatic t_link;
      rd(5'h17, 16'h3048);
      rd(5'h18, 16'h0000);
      plc_host_inst.acc(1'b1, 5'h17, 16'hFFFF);
      rd(5'h17, 16'h3FFF);
      plc_host_inst.acc(1'b1, 5'h17, 16'h0000);
      `CHK({link_attempt_enable, standby, speed_retry_count}, 5'h08)
   endtask : t_link
   task automatic t_irq(input logic [15:0] m);
      plc_host_inst.acc(1'b1, 5'h18, m);
      rd(5'h18, m);
      for (int i = 0; i < 10; i++) begin
         @(posedge ref_clk);
         int_event <= 10'h1 << i;
         @(posedge ref_clk);
         int_event <= 10'h0;
         #1;
         `CHK(int_n, ~(m[0] & m[i + 1]))
         rd(5'h19, (16'h0002 << i) | {15'h0000, m[i + 1]});
         `CHK(int_n, 1'b1)
      end
   endtask : t_irq
   task automatic results;
      if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   initial begin
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_link();
      t_irq(16'h07FF);
      t_irq(16'h07FE);
      t_irq(16'h0001);
      results();
   end
   initial begin
      #20us;
      err_total++;
      results();
   end
endmodule : plc_link_ctrl_irq_mask_tb
`default_nettype wire
